// ===== logic/crce_pkg.sv
// constants for the programmable crc engine: register indices,
// field positions, reset values and queue depths.
// assumes a 16-bit cpu special-function-register port, one word per index.
package crce_pkg;

    // register indices on the sfr port
    localparam logic [2:0] IDX_CTRL1     = 3'h0;
    localparam logic [2:0] IDX_CTRL2     = 3'h1;
    localparam logic [2:0] IDX_TAPS_LO   = 3'h2;
    localparam logic [2:0] IDX_TAPS_HI   = 3'h3;
    localparam logic [2:0] IDX_IN_LO     = 3'h4;
    localparam logic [2:0] IDX_IN_HI     = 3'h5;
    localparam logic [2:0] IDX_SHIFT_LO  = 3'h6;
    localparam logic [2:0] IDX_SHIFT_HI  = 3'h7;

    // control word 1 field positions
    localparam int POS_MODULE_ON  = 15;
    localparam int POS_COUNT_LSB  = 8;
    localparam int POS_FULL       = 7;
    localparam int POS_EMPTY      = 6;
    localparam int POS_GO         = 4;
    localparam int POS_LSB_FIRST  = 3;

    // control word 2 field positions
    localparam int POS_WIDTH_LSB  = 8;
    localparam int POS_PLEN_LSB   = 0;

    // reset values
    localparam logic [15:0] RST_TAPS   = 16'h0000;
    localparam logic [31:0] RST_SHIFT  = 32'h0000_0000;
    localparam logic [4:0]  RST_FIELD  = 5'h00;

    // queue depth per word width band
    localparam logic [4:0] DEPTH_BYTE  = 5'h10;
    localparam logic [4:0] DEPTH_HALF  = 5'h08;
    localparam logic [4:0] DEPTH_WORD  = 5'h04;
    localparam logic [4:0] LIMIT_BYTE  = 5'h07;
    localparam logic [4:0] LIMIT_HALF  = 5'h0F;

    // bits fed to the engine per clock: shift clock is twice the
    // instruction rate
    localparam logic [5:0] BITS_PER_CLK = 6'h02;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_SHIFT
    } crce_state_t;

endpackage : crce_pkg

// ===== logic/crce_store.sv
// word store for the crc input queue; one write port, one read port.
// assumes addresses in range; read data appear one clock after rd_en.
`timescale 1ns/1ps
`default_nettype none
module crce_store #(
    parameter int WIDTH  = 32,
    parameter int ADDR_W = 4
) (
    // clock
    input  wire logic              clk,
    input  wire logic              ce,
    // write side
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]  wr_data,
    // read side
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [WIDTH-1:0]  rd_data
);

    logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

    // no reset on the array: stale entries are never counted as valid
    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : crce_store
`default_nettype wire

// ===== logic/crce_top.sv
// programmable bit-serial crc engine with input queue and sfr port.
// assumes a cpu-side register port on CLK, one access per cycle at most.
//
// Contract
// - low tap register holds terms 1-15 in bits 15:1; bit 0 reads zero.
// - high tap register holds terms 16-31, read/write, zero after reset.
// - input word writes feed the queue; reading them always returns zero.
// - shift register halves are writable directly; reads return crc result.
// - set tap bit xors feedback into its stage; clear bit passes through.
// - length field selects feedback stage; polynomial length is field plus one.
// - polynomials up to order 32 with a 32-bit shift register.
// - constant term always applied at stage zero; tap bit 0 ignored.
// - highest-order term's tap bit has no effect on the result.
// - word width field configures data width from 1 to 32 bits.
// - widths up to 16 use only low input word; high writes ignored.
// - direction bit zero shifts msb first; one shifts lsb first.
// - direction only reorders input bits; result is never reflected.
// - engine is a bit-serial shifter with register-selected taps.
// - queue depth is 16, 8 or 4 words by configured width band.
// - shifting proceeds with go set and count nonzero; count drops per fetch.
// - word width field holds data width minus one.
// - engine consumes two data bits per clock.
`timescale 1ns/1ps
`default_nettype none
module crce_top
    import crce_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // clock, reset, enable
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    // register port
    input  wire logic [2:0]  ADDR,
    input  wire logic        WR,
    input  wire logic        RD,
    input  wire logic [1:0]  BE,
    input  wire logic [15:0] WDATA,
    output logic      [15:0] RDATA,
    // status
    output logic             BUSY
);

    // configuration and status state
    logic              module_on;
    logic              shift_go;
    logic              lsb_first_select;
    logic [4:0]        word_width_field;
    logic [4:0]        poly_length_field;
    logic [15:0]       poly_taps_low;
    logic [15:0]       poly_taps_high;
    logic [31:0]       crc;
    logic [15:0]       hold_low;
    logic              pend;
    logic [7:0]        pend_byte;
    logic [ADDR_W-1:0] wr_ptr;
    logic [ADDR_W-1:0] rd_ptr;
    logic [4:0]        valid_word_count;
    crce_state_t       state;
    logic [31:0]       sbuf;
    logic [5:0]        remain;

    // combinational
    logic              queue_full_flag;
    logic              byte_mode;
    logic              wide_mode;
    logic              push;
    logic [31:0]       push_data;
    logic              next_pend;
    logic              pop;
    logic [31:0]       rd_word;
    logic [31:0]       taps;
    logic [31:0]       len_mask;
    logic [31:0]       next_crc1;
    logic [31:0]       next_crc2;
    logic [4:0]        next_count;

    function automatic logic wr_hit(input logic [2:0] idx);
        wr_hit = WR && (ADDR == idx);
    endfunction : wr_hit

    // queue limit for a width setting
    function automatic logic [4:0] max_words(input logic [4:0] wfield);
        if (wfield <= LIMIT_BYTE) begin
            max_words = DEPTH_BYTE;
        end else if (wfield <= LIMIT_HALF) begin
            max_words = DEPTH_HALF;
        end else begin
            max_words = DEPTH_WORD;
        end
    endfunction : max_words

    // one serial step: feedback to stage zero and to each enabled tap
    function automatic logic [31:0] crc_step(input logic [31:0] cur,
                                             input logic        din);
        logic        fb;
        logic [31:0] nxt;
        fb = cur[poly_length_field] ^ din;
        nxt[0] = fb;
        for (int i = 1; i < 32; i++) begin
            nxt[i] = cur[i-1] ^ (taps[i] & fb);
        end
        // bits above the length are cleared, dropping the top term
        crc_step = nxt & len_mask;
    endfunction : crc_step

    assign taps      = {poly_taps_high, poly_taps_low};
    assign len_mask  = 32'hFFFF_FFFF >> (5'd31 - poly_length_field);
    assign byte_mode = (word_width_field <= LIMIT_BYTE);
    assign wide_mode = (word_width_field > LIMIT_HALF);
    assign queue_full_flag =
        (valid_word_count >= max_words(word_width_field));

    // queue fill
    always_comb begin
        push      = 1'b0;
        push_data = 32'h0000_0000;
        next_pend = 1'b0;
        if (!module_on) begin
            push = 1'b0;
        end else if (pend) begin
            push      = !queue_full_flag;
            push_data = {24'h00_0000, pend_byte};
        end else if (wr_hit(IDX_IN_LO) && !wide_mode) begin
            if (byte_mode) begin
                if (BE[0]) begin
                    push      = !queue_full_flag;
                    push_data = {16'h0000, WDATA};
                    next_pend = BE[1];
                end else if (BE[1]) begin
                    push      = !queue_full_flag;
                    push_data = {24'h00_0000, WDATA[15:8]};
                end
            end else begin
                push      = !queue_full_flag;
                push_data = {16'h0000, WDATA};
            end
        end else if (wr_hit(IDX_IN_HI) && wide_mode) begin
            push      = !queue_full_flag;
            push_data = {WDATA, hold_low};
        end
    end

    assign pop = module_on && shift_go && (state == ST_IDLE)
                 && (valid_word_count != 5'h00);

    always_comb begin
        next_count = valid_word_count;
        if (push && !pop) begin
            next_count = valid_word_count + 5'h01;
        end else if (pop && !push) begin
            next_count = valid_word_count - 5'h01;
        end
    end

    crce_store #(
        .WIDTH  (32),
        .ADDR_W (ADDR_W)
    ) u_store (
        .clk     (CLK),
        .ce      (CE),
        .wr_en   (push),
        .wr_addr (wr_ptr),
        .wr_data (push_data),
        .rd_en   (pop),
        .rd_addr (rd_ptr),
        .rd_data (rd_word)
    );

    // queue pointers, count and the split byte of a two-byte write
    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_ptr           <= '0;
            rd_ptr           <= '0;
            valid_word_count <= 5'h00;
            pend             <= 1'b0;
            pend_byte        <= 8'h00;
        end else if (CE) begin
            if (!module_on) begin
                wr_ptr           <= '0;
                rd_ptr           <= '0;
                valid_word_count <= 5'h00;
                pend             <= 1'b0;
            end else begin
                if (push) begin
                    wr_ptr <= wr_ptr + 1'b1;
                end
                if (pop) begin
                    rd_ptr <= rd_ptr + 1'b1;
                end
                valid_word_count <= next_count;
                pend             <= next_pend;
                if (next_pend) begin
                    pend_byte <= WDATA[15:8];
                end
            end
        end
    end

    // low half waits here until the high half completes the word
    always_ff @(posedge CLK) begin
        if (RST) begin
            hold_low <= 16'h0000;
        end else if (CE && wr_hit(IDX_IN_LO) && wide_mode) begin
            hold_low <= WDATA;
        end
    end

    // control and polynomial registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            module_on         <= 1'b0;
            shift_go          <= 1'b0;
            lsb_first_select  <= 1'b0;
            word_width_field  <= RST_FIELD;
            poly_length_field <= RST_FIELD;
            poly_taps_low     <= RST_TAPS;
            poly_taps_high    <= RST_TAPS;
        end else if (CE) begin
            if (wr_hit(IDX_CTRL1) && BE[1]) begin
                module_on <= WDATA[POS_MODULE_ON];
            end
            if (wr_hit(IDX_CTRL1) && BE[0]) begin
                shift_go         <= WDATA[POS_GO];
                lsb_first_select <= WDATA[POS_LSB_FIRST];
            end
            if (wr_hit(IDX_CTRL2) && BE[1]) begin
                word_width_field <= WDATA[POS_WIDTH_LSB +: 5];
            end
            if (wr_hit(IDX_CTRL2) && BE[0]) begin
                poly_length_field <= WDATA[POS_PLEN_LSB +: 5];
            end
            if (wr_hit(IDX_TAPS_LO)) begin
                if (BE[0]) begin
                    poly_taps_low[7:0] <= {WDATA[7:1], 1'b0};
                end
                if (BE[1]) begin
                    poly_taps_low[15:8] <= WDATA[15:8];
                end
            end
            if (wr_hit(IDX_TAPS_HI)) begin
                if (BE[0]) begin
                    poly_taps_high[7:0] <= WDATA[7:0];
                end
                if (BE[1]) begin
                    poly_taps_high[15:8] <= WDATA[15:8];
                end
            end
        end
    end

    // serial steps for this clock
    assign next_crc1 = crc_step(crc, lsb_first_select ? sbuf[0] : sbuf[31]);
    assign next_crc2 = crc_step(next_crc1,
                                lsb_first_select ? sbuf[1] : sbuf[30]);

    // engine sequencing: fetch a word, then shift two bits per clock
    always_ff @(posedge CLK) begin
        if (RST) begin
            state  <= ST_IDLE;
            sbuf   <= 32'h0000_0000;
            remain <= 6'h00;
            BUSY   <= 1'b0;
        end else if (CE) begin
            unique case (state)
                ST_IDLE: begin
                    if (pop) begin
                        state <= ST_FETCH;
                        BUSY  <= 1'b1;
                    end
                end
                ST_FETCH: begin
                    // msb-first aligns the top used bit to bit 31 so
                    // unused upper bits fall off
                    if (lsb_first_select) begin
                        sbuf <= rd_word;
                    end else begin
                        sbuf <= rd_word << (5'd31 - word_width_field);
                    end
                    remain <= {1'b0, word_width_field} + 6'h01;
                    state  <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (shift_go) begin
                        if (lsb_first_select) begin
                            sbuf <= sbuf >> BITS_PER_CLK;
                        end else begin
                            sbuf <= sbuf << BITS_PER_CLK;
                        end
                        if (remain <= BITS_PER_CLK) begin
                            remain <= 6'h00;
                            state  <= ST_IDLE;
                            BUSY   <= 1'b0;
                        end else begin
                            remain <= remain - BITS_PER_CLK;
                        end
                    end
                end
            endcase
            if (!module_on) begin
                state <= ST_IDLE;
                BUSY  <= 1'b0;
            end
        end
    end

    // crc register: a cpu write wins over a shift step in the same clock
    always_ff @(posedge CLK) begin
        if (RST) begin
            crc <= RST_SHIFT;
        end else if (CE) begin
            if (state == ST_SHIFT && shift_go && module_on) begin
                if (remain >= BITS_PER_CLK) begin
                    crc <= next_crc2;
                end else begin
                    crc <= next_crc1;
                end
            end
            if (wr_hit(IDX_SHIFT_LO)) begin
                if (BE[0]) begin
                    crc[7:0] <= WDATA[7:0];
                end
                if (BE[1]) begin
                    crc[15:8] <= WDATA[15:8];
                end
            end
            if (wr_hit(IDX_SHIFT_HI)) begin
                if (BE[0]) begin
                    crc[23:16] <= WDATA[7:0];
                end
                if (BE[1]) begin
                    crc[31:24] <= WDATA[15:8];
                end
            end
        end
    end

    // read data, one clock after RD
    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= 16'h0000;
        end else if (CE && RD) begin
            RDATA <= 16'h0000;
            unique case (ADDR)
                IDX_CTRL1: begin
                    RDATA[POS_MODULE_ON]        <= module_on;
                    RDATA[POS_COUNT_LSB +: 5]   <= valid_word_count;
                    RDATA[POS_FULL]             <= queue_full_flag;
                    RDATA[POS_EMPTY]            <= (valid_word_count == 5'h00);
                    RDATA[POS_GO]               <= shift_go;
                    RDATA[POS_LSB_FIRST]        <= lsb_first_select;
                end
                IDX_CTRL2: begin
                    RDATA[POS_WIDTH_LSB +: 5] <= word_width_field;
                    RDATA[POS_PLEN_LSB +: 5]  <= poly_length_field;
                end
                IDX_TAPS_LO:  RDATA <= poly_taps_low;
                IDX_TAPS_HI:  RDATA <= poly_taps_high;
                IDX_IN_LO:    RDATA <= 16'h0000;
                IDX_IN_HI:    RDATA <= 16'h0000;
                IDX_SHIFT_LO: RDATA <= crc[15:0];
                IDX_SHIFT_HI: RDATA <= crc[31:16];
            endcase
        end
    end

endmodule : crce_top
`default_nettype wire

// ===== verification/crce_top_assertions.sv
// port-level checker for the crc engine top, attached by bind.
// assumes CE stays high while a checked sequence is in flight.
`timescale 1ns/1ps
`default_nettype none
module crce_top_assertions
    import crce_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // clock, reset, enable
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        CE,
    // register port
    input wire logic [2:0]  ADDR,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [1:0]  BE,
    input wire logic [15:0] WDATA,
    input wire logic [15:0] RDATA,
    // status
    input wire logic        BUSY
);
    logic       on;
    logic       go;
    logic [4:0] wfield;

    // shadow of the control bits that gate the engine
    always_ff @(posedge CLK) begin
        if (RST) begin
            on <= 1'b0;
            go <= 1'b0;
            wfield <= 5'h00;
        end else if (CE && WR && ADDR == IDX_CTRL1) begin
            if (BE[1]) on <= WDATA[POS_MODULE_ON];
            if (BE[0]) go <= WDATA[POS_GO];
        end else if (CE && WR && ADDR == IDX_CTRL2 && BE[1]) begin
            wfield <= WDATA[POS_WIDTH_LSB +: 5];
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_reset_clears: assert property ($fell(RST) |-> RDATA == 16'h0000 && !BUSY)
        else $error("read data or busy not clear after reset");
    a_data_reads_zero: assert property (RD && CE && (ADDR == IDX_IN_LO ||
        ADDR == IDX_IN_HI) |=> RDATA == 16'h0000)
        else $error("input word read returned nonzero");
    a_taps_low_rw: assert property (WR && CE && ADDR == IDX_TAPS_LO && BE == 2'b11
        ##2 RD && CE && ADDR == IDX_TAPS_LO
        |=> RDATA == ($past(WDATA, 3) & 16'hFFFE))
        else $error("low tap readback wrong");
    a_taps_high_rw: assert property (WR && CE && ADDR == IDX_TAPS_HI && BE == 2'b11
        ##2 RD && CE && ADDR == IDX_TAPS_HI |=> RDATA == $past(WDATA, 3))
        else $error("high tap readback wrong");
    a_rdata_holds: assert property (!(RD && CE) |=> $stable(RDATA))
        else $error("read data changed without a read");
    a_shift_low_rw: assert property (WR && CE && ADDR == IDX_SHIFT_LO && BE == 2'b11
        && !BUSY ##1 !BUSY ##1 RD && CE && ADDR == IDX_SHIFT_LO && !BUSY
        |=> RDATA == $past(WDATA, 3))
        else $error("shift register low readback wrong");
    a_push_starts: assert property (WR && CE && ADDR == IDX_IN_LO && BE == 2'b01
        && on && go && wfield <= 5'h07 && !BUSY |-> ##[1:4] BUSY)
        else $error("pushed byte did not start the engine");
    a_byte_busy_time: assert property ($rose(BUSY) && wfield == 5'h07
        |-> BUSY [*5] ##1 !BUSY)
        else $error("byte word busy time wrong");

    c_byte_run: cover property ($rose(BUSY) && wfield == 5'h07);
    c_wide_run: cover property ($rose(BUSY) && wfield > 5'h0F);
    c_data_read: cover property (RD && CE && ADDR == IDX_IN_HI);
endmodule : crce_top_assertions

bind crce_top crce_top_assertions #(.ADDR_W(ADDR_W)) crce_top_assertions_inst (
    .CLK(CLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WR(WR), .RD(RD), .BE(BE),
    .WDATA(WDATA), .RDATA(RDATA), .BUSY(BUSY));
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the crc engine: registers, queue depth and
// crc results against a bit-level model kept in the bench.
// assumes the checker file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import crce_pkg::*;
    logic        CLK;
    logic        RST;
    logic        CE;
    logic [2:0]  ADDR;
    logic        WR;
    logic        RD;
    logic [1:0]  BE;
    logic [15:0] WDATA;
    logic [15:0] RDATA;
    logic        BUSY;
    int          n_fail = 0;
    int          n_compared = 0;
    int          cycles = 0;
    integer      seed;
    logic [15:0] rv;
    logic [15:0] tap_lo;
    logic [15:0] tap_hi;
    logic [31:0] crc;
    logic [31:0] w;
    logic [31:0] q[$];
    int          wd;
    int          dep;
    int          live;
    int          k;
    int          idle;
    // width field, length field, lsb first, words, go set while pushing
    int wf_t[6] = '{7, 4, 0, 11, 23, 31};
    int pl_t[6] = '{15, 7, 3, 31, 20, 31};
    int ls_t[6] = '{0, 1, 0, 1, 0, 1};
    int nw_t[6] = '{18, 3, 5, 10, 6, 3};
    int lv_t[6] = '{0, 1, 0, 0, 0, 1};

    crce_top #(.ADDR_W(4)) crce_top_inst (
        .CLK(CLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WR(WR), .RD(RD),
        .BE(BE), .WDATA(WDATA), .RDATA(RDATA), .BUSY(BUSY));

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task automatic end_of_test;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // a hang counts as a mismatch
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // one idle cycle follows every access, so no pending byte is lost
    task automatic wr(input logic [2:0] a, input logic [15:0] d,
                      input logic [1:0] be);
        @(posedge CLK);
        #1;
        ADDR = a;
        BE = be;
        WDATA = d;
        WR = 1'b1;
        @(posedge CLK);
        #1;
        WR = 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge CLK);
        #1;
        ADDR = a;
        RD = 1'b1;
        @(posedge CLK);
        #1;
        RD = 1'b0;
        d = RDATA;
    endtask : rd

    task automatic push(input logic [31:0] x);
        if (live != 0 || q.size() < dep) q.push_back(x);
    endtask : push

    function automatic logic [31:0] mstep(input logic [31:0] c,
                                          input logic [31:0] x);
        logic fb;
        for (int j = 0; j < wd; j++) begin
            fb = c[pl_t[k]] ^ (ls_t[k] != 0 ? x[j] : x[wd - 1 - j]);
            c = (c << 1) ^ ({tap_hi, tap_lo[15:1], 1'b0} & {32{fb}});
            c[0] = fb;
            if (pl_t[k] < 31) c = c & ~(32'hFFFF_FFFF << (pl_t[k] + 1));
        end
        return c;
    endfunction : mstep

    initial begin
        seed = 32'h0000_7cc5;
        RST = 1'b1;
        CE = 1'b1;
        ADDR = 3'h0;
        WR = 1'b0;
        RD = 1'b0;
        BE = 2'b00;
        WDATA = 16'h0000;
        repeat (6) @(posedge CLK);
        #1;
        RST = 1'b0;
        for (int a = 2; a < 8; a++) begin
            rd(3'(a), rv);
            chk("reset value", 32'h0000_0000, {16'h0000, rv});
        end
        for (int r = 0; r < 6; r++) begin
            wd = wf_t[r] + 1;
            dep = wd <= 8 ? 16 : (wd <= 16 ? 8 : 4);
            live = lv_t[r];
            wr(IDX_CTRL1, 16'h0000, 2'b11);
            wr(IDX_CTRL2, 16'((wf_t[r] << POS_WIDTH_LSB) | pl_t[r]), 2'b11);
            wr(IDX_CTRL1, 16'(32'h0000_8000 | (live << POS_GO)
                | (ls_t[r] << POS_LSB_FIRST)), 2'b11);
            tap_lo = 16'($random(seed));
            tap_hi = 16'($random(seed));
            crc = $random(seed);
            wr(IDX_TAPS_LO, tap_lo, 2'b11);
            rd(IDX_TAPS_LO, rv);
            chk("taps low", {16'h0000, tap_lo & 16'hFFFE}, {16'h0000, rv});
            wr(IDX_TAPS_HI, tap_hi, 2'b11);
            rd(IDX_TAPS_HI, rv);
            chk("taps high", {16'h0000, tap_hi}, {16'h0000, rv});
            wr(IDX_SHIFT_LO, crc[15:0], 2'b11);
            rd(IDX_SHIFT_LO, rv);
            chk("shift low", {16'h0000, crc[15:0]}, {16'h0000, rv});
            wr(IDX_SHIFT_HI, crc[31:16], 2'b11);
            q.delete();
            k = 0;
            while (k < nw_t[r]) begin
                // random words stand for data that software has already
                // byte- and word-swapped for msb-first mode
                w = $random(seed);
                if (wd > 16) begin
                    wr(IDX_IN_LO, w[15:0], 2'b11);
                    wr(IDX_IN_HI, w[31:16], 2'b11);
                    push(w);
                    k++;
                end else if (wd > 8) begin
                    wr(IDX_IN_LO, w[15:0], 2'b11);
                    wr(IDX_IN_HI, w[31:16], 2'b11);
                    push({16'h0000, w[15:0]});
                    k++;
                end else if (k + 1 < nw_t[r] && w[16]) begin
                    wr(IDX_IN_LO, w[15:0], 2'b11);
                    push({24'h00_0000, w[7:0]});
                    push({24'h00_0000, w[15:8]});
                    k += 2;
                end else begin
                    wr(IDX_IN_LO, w[15:0], 2'b01);
                    push({24'h00_0000, w[7:0]});
                    k++;
                end
            end
            if (live == 0) begin
                rd(IDX_CTRL1, rv);
                chk("count full empty",
                    32'({5'(q.size()), q.size() == dep, q.size() == 0}),
                    32'({rv[12:8], rv[POS_FULL], rv[POS_EMPTY]}));
                wr(IDX_CTRL1, 16'(32'h0000_8010 | (ls_t[r] << POS_LSB_FIRST)),
                    2'b11);
            end
            k = r;
            foreach (q[i]) crc = mstep(crc, q[i]);
            idle = 0;
            for (int t = 0; t < 500 && idle < 2; t++) begin
                rd(IDX_CTRL1, rv);
                idle = (rv[12:8] == 5'h00 && BUSY === 1'b0) ? idle + 1 : 0;
            end
            rd(IDX_SHIFT_LO, w[15:0]);
            rd(IDX_SHIFT_HI, w[31:16]);
            chk("crc result", crc, w);
        end
        // a write offered while the clock enable is low must be dropped
        wr(IDX_TAPS_HI, 16'h5A5A, 2'b11);
        @(posedge CLK);
        #1;
        CE = 1'b0;
        WDATA = 16'($random(seed));
        WR = 1'b1;
        repeat (3) @(posedge CLK);
        #1;
        CE = 1'b1;
        WR = 1'b0;
        rd(IDX_TAPS_HI, rv);
        chk("frozen taps", 32'h0000_5A5A, {16'h0000, rv});
        end_of_test();
    end
endmodule : tb
`default_nettype wire
